// ---- src/tptx_top.v ----
// First transmit port pattern FIFO path and board status register.
// Assumes synchronous inputs, one host access per strobe and fixed FIFO depth.
//
// How it works
// - fifteen FIFO flags in low half active low
// - empty and full bits at fixed positions
// - lockstep FIFOs share their main flags
// - bits 2 and 8 mirror receive enables
// - bit 5 is masked transmit read enables
// - bit 11 returns the chain TDO
// - bits 12 to 15 side receive flags
// - upper sixteen bits from user status
// - clear-error bit 29 clears error bits
// - error bits stay set until cleared
// - bits 16 and 17 are link ready
// - receiver error inputs set error bits
// - third transmitter write sets overwrite bit
// - status register is read only
// - main FIFO bits 0-25 drive data pins
// - stop bit ends the sequence read
// - one word per cycle once started
// - side word bits feed both pin groups
// - side outputs enabled by mode bits 31, 30 and 3, not by the sequencer
// - side FIFO read in lockstep with main
`timescale 1ns/100ps
`default_nettype none
`include "tptx_consts.vh"

module tptx_top (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Host register port
    input wire host_wr,
    input wire host_rd,
    input wire [1:0] host_sel,
    input wire [31:0] host_wdata,
    output reg [31:0] host_rdata_q,
    // Control and mode
    input wire [31:0] control_word,
    input wire [31:0] mode_word,
    input wire tx_start,
    input wire tx_stop,
    input wire tx_retransmit,
    input wire tx_reset,
    // First transmit port pins
    output reg [25:0] transmit_data_pins_q,
    output reg [1:0] ctrl_top_bits_q,
    output reg ctrl_stop_q,
    output reg tx_active_q,
    // Side bidirectional pins
    input wire [8:0] tx_port_io_in,
    output reg [8:0] tx_port_io_out_q,
    output reg tx_port_io_oe_q,
    input wire [8:0] rx_port_io_in,
    output reg [8:0] rx_port_io_out_q,
    output reg rx_port_io_oe_q,
    output reg [3:0] side_top_pins_q,
    // Flags from other FIFO chips and ports
    input wire rx1_empty_n,
    input wire rx1_full_n,
    input wire rx1_wen_n,
    input wire rx2_empty_n,
    input wire rx2_full_n,
    input wire rx2_wen_n,
    input wire tx2_empty_n,
    input wire tx2_full_n,
    input wire tx2_ren_n,
    input wire rx1_side_empty_n,
    input wire rx1_side_full_n,
    input wire rx2_side_empty_n,
    input wire rx2_side_full_n,
    input wire jtag_tdo,
    // User status sources
    input wire ready_for_data,
    input wire link_ready_n,
    input wire code_violation_flag,
    input wire link_rx_error,
    input wire link_tx_load,
    input wire link_tx_unload,
    input wire [10:0] user_error_events,
    // Status word view
    output wire [31:0] board_status
);

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_DONE = 3'b100;

    localparam [14:0] DEPTH = 15'h4000;

    reg [2:0] state_q;
    reg [2:0] state_d;

    // Each lockstep FIFO has its own write pointer and count; only the read pointer is shared.
    reg [13:0] main_wp_q;
    reg [13:0] side_wp_q;
    reg [13:0] rp_q;
    reg [14:0] main_cnt_q;
    reg [14:0] side_cnt_q;
    reg rd_valid_q;
    reg [1:0] link_fill_q;
    reg overwrite_q;

    wire [26:0] main_rdata;
    wire [17:0] side_rdata;
    wire port_sel;
    wire main_full;
    wire main_empty;
    wire side_full;
    wire main_wr;
    wire side_wr;
    wire rd_en;
    wire stop_seen;
    wire tx_io_tx;
    wire rx_io_tx;
    wire tx_ren_n;
    wire [15:0] low_flags_n;
    wire [13:0] err_events;
    wire clear_errors;

    function is_full;
        input [14:0] cnt;
        begin
            is_full = (cnt == DEPTH);
        end
    endfunction

    assign port_sel = mode_word[`TPTX_MODE_SEL_T1];
    assign main_full = is_full(main_cnt_q);
    assign side_full = is_full(side_cnt_q);
    assign main_empty = (main_cnt_q == 15'h0000);
    assign tx_io_tx = ~mode_word[31];
    assign rx_io_tx = ~mode_word[30];

    // ----------------------------------------
    // Host writes
    // ----------------------------------------
    // drop writes when full
    assign main_wr = host_wr && (host_sel == `TPTX_SEL_MAIN) && !main_full && port_sel;
    assign side_wr = host_wr && (host_sel == `TPTX_SEL_SIDE) && !side_full && port_sel;

    assign rd_en = (state_q == ST_RUN) && !main_empty && port_sel;
    assign stop_seen = rd_valid_q && main_rdata[`TPTX_STOP_BIT];

    tptx_mem #(
        .WIDTH(`TPTX_MAIN_W),
        .AW(`TPTX_FIFO_AW)
    ) u_main_mem (
        .core_clk(core_clk),
        .wr_en(main_wr),
        .wr_addr(main_wp_q),
        .wr_data(host_wdata[26:0]),
        .rd_en(rd_en),
        .rd_addr(rp_q),
        .rd_data_q(main_rdata)
    );

    tptx_mem #(
        .WIDTH(`TPTX_SIDE_FW),
        .AW(`TPTX_FIFO_AW)
    ) u_side_mem (
        .core_clk(core_clk),
        .wr_en(side_wr),
        .wr_addr(side_wp_q),
        .wr_data(host_wdata[31:14]),
        .rd_en(rd_en),
        .rd_addr(rp_q),
        .rd_data_q(side_rdata)
    );

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (tx_start && port_sel)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (stop_seen || tx_stop || !port_sel)
                begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            main_wp_q <= 14'h0000;
            side_wp_q <= 14'h0000;
            rp_q <= 14'h0000;
            main_cnt_q <= 15'h0000;
            side_cnt_q <= 15'h0000;
            rd_valid_q <= 1'b0;
        end
        else if (tx_reset)
        begin
            state_q <= ST_IDLE;
            main_wp_q <= 14'h0000;
            side_wp_q <= 14'h0000;
            rp_q <= 14'h0000;
            main_cnt_q <= 15'h0000;
            side_cnt_q <= 15'h0000;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            state_q <= (tx_retransmit) ? ST_IDLE : state_d;
            rd_valid_q <= rd_en;
            if (main_wr)
            begin
                main_wp_q <= main_wp_q + 14'h0001;
            end
            if (side_wr)
            begin
                side_wp_q <= side_wp_q + 14'h0001;
            end
            if (tx_retransmit)
            begin
                // Rewind replays everything written so far.
                rp_q <= 14'h0000;
                main_cnt_q <= {1'b0, main_wp_q} + {14'h0000, main_wr};
                side_cnt_q <= {1'b0, side_wp_q} + {14'h0000, side_wr};
            end
            else
            begin
                if (rd_en)
                begin
                    rp_q <= rp_q + 14'h0001;
                end
                main_cnt_q <= main_cnt_q + {14'h0000, main_wr} - {14'h0000, rd_en};
                side_cnt_q <= side_cnt_q + {14'h0000, side_wr}
                              - {14'h0000, rd_en && (side_cnt_q != 15'h0000)};
            end
        end
    end

    // ----------------------------------------
    // Output buffers
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transmit_data_pins_q <= 26'h0000000;
            ctrl_top_bits_q <= 2'h0;
            ctrl_stop_q <= 1'b0;
            tx_active_q <= 1'b0;
            tx_port_io_out_q <= 9'h000;
            rx_port_io_out_q <= 9'h000;
            tx_port_io_oe_q <= 1'b0;
            rx_port_io_oe_q <= 1'b0;
            side_top_pins_q <= 4'h0;
        end
        else
        begin
            tx_active_q <= rd_en;
            ctrl_stop_q <= stop_seen;
            tx_port_io_oe_q <= tx_io_tx && port_sel;
            rx_port_io_oe_q <= rx_io_tx && port_sel;
            side_top_pins_q <= {tx_io_tx ? tx_port_io_out_q[8:7] : tx_port_io_in[8:7],
                                rx_io_tx ? rx_port_io_out_q[8:7] : rx_port_io_in[8:7]};
            if (rd_valid_q)
            begin
                transmit_data_pins_q <= main_rdata[`TPTX_DATA_MSB:0];
                ctrl_top_bits_q <= main_rdata[`TPTX_STOP_BIT:`TPTX_DATA_MSB];
                tx_port_io_out_q <= side_rdata[17:9];
                rx_port_io_out_q <= side_rdata[8:0];
            end
        end
    end

    // ----------------------------------------
    // Link transmitter overwrite tracking
    // ----------------------------------------
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_fill_q <= 2'h0;
            overwrite_q <= 1'b0;
        end
        else
        begin
            overwrite_q <= link_tx_load && (link_fill_q == 2'h2) && !link_tx_unload;
            if (link_tx_load && !link_tx_unload && (link_fill_q != 2'h2))
            begin
                link_fill_q <= link_fill_q + 2'h1;
            end
            else if (!link_tx_load && link_tx_unload && (link_fill_q != 2'h0))
            begin
                link_fill_q <= link_fill_q - 2'h1;
            end
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    // masked transmit read enables
    assign tx_ren_n = ~((tx_active_q & port_sel) |
                        (~tx2_ren_n & mode_word[`TPTX_MODE_SEL_T2])) ? 1'b1 : 1'b0;

    assign low_flags_n = {rx1_side_full_n, rx1_side_empty_n,
                          rx2_side_full_n, rx2_side_empty_n,
                          jtag_tdo, ~main_full, ~main_empty, rx1_wen_n,
                          rx1_full_n, rx1_empty_n, tx_ren_n,
                          tx2_full_n, tx2_empty_n, rx2_wen_n,
                          rx2_full_n, rx2_empty_n};

    assign err_events = {link_rx_error, code_violation_flag, overwrite_q, user_error_events};
    assign clear_errors = control_word[`TPTX_CTL_CLR_ERR];

    tptx_status u_status (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .low_flags_n(low_flags_n),
        .tx_ready_for_data(ready_for_data),
        .link_ready_n(link_ready_n),
        .err_events(err_events),
        .clear_errors(clear_errors),
        .status_q(board_status)
    );

    // ----------------------------------------
    // Host reads
    // ----------------------------------------
    // status only readable
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            host_rdata_q <= 32'h00000000;
        end
        else if (host_rd && (host_sel == `TPTX_SEL_STATUS))
        begin
            host_rdata_q <= board_status;
        end
        else if (host_rd)
        begin
            host_rdata_q <= 32'h00000000;
        end
    end

endmodule // tptx_top
`default_nettype wire

// ---- src/tptx_consts.vh ----
// Constants for the first transmit port pattern path and the board status word.
// Assumes a 32-bit host data path and one 250 MHz system clock.
`ifndef TPTX_CONSTS_VH
`define TPTX_CONSTS_VH

// ----------------------------------------
// Register selects
// ----------------------------------------
`define TPTX_SEL_STATUS 2'h0
`define TPTX_SEL_MAIN 2'h1
`define TPTX_SEL_SIDE 2'h2

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define TPTX_ST_RX2_EMPTY 0
`define TPTX_ST_RX2_FULL 1
`define TPTX_ST_RX2_WEN 2
`define TPTX_ST_TX2_EMPTY 3
`define TPTX_ST_TX2_FULL 4
`define TPTX_ST_TX_REN 5
`define TPTX_ST_RX1_EMPTY 6
`define TPTX_ST_RX1_FULL 7
`define TPTX_ST_RX1_WEN 8
`define TPTX_ST_TX1_EMPTY 9
`define TPTX_ST_TX1_FULL 10
`define TPTX_ST_TDO 11
`define TPTX_ST_RX2S_EMPTY 12
`define TPTX_ST_RX2S_FULL 13
`define TPTX_ST_RX1S_EMPTY 14
`define TPTX_ST_RX1S_FULL 15
`define TPTX_ST_TXRDY 16
`define TPTX_ST_RXRDY 17
`define TPTX_USER_LSB 16
`define TPTX_STICKY_MASK 16'hfffc

// ----------------------------------------
// Pattern word fields
// ----------------------------------------
`define TPTX_DATA_MSB 25
`define TPTX_STOP_BIT 26
`define TPTX_SIDE_UP_LSB 23
`define TPTX_SIDE_LO_LSB 14
`define TPTX_SIDE_W 9
`define TPTX_MAIN_W 27
`define TPTX_SIDE_FW 18

// ----------------------------------------
// Control and mode bits
// ----------------------------------------
`define TPTX_CTL_CLR_ERR 29
`define TPTX_MODE_SEL_T1 3
`define TPTX_MODE_SEL_T2 1

// ----------------------------------------
// FIFO geometry
// ----------------------------------------
`define TPTX_FIFO_AW 14
`define TPTX_FIFO_DEPTH 16384

`endif

// ---- src/tptx_mem.v ----
// Simple dual-port pattern memory with registered read data.
// Assumes the owner keeps write and read addresses in range.
`timescale 1ns/100ps
`default_nettype none

module tptx_mem #(
    parameter WIDTH = 27,
    parameter AW = 14
) (
    // Clock
    input wire core_clk,
    // Write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // Read side
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data_q
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule // tptx_mem
`default_nettype wire

// ---- src/tptx_status.v ----
// Board status word: live FIFO flags plus user status with sticky error bits.
// Assumes all flag and event inputs are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tptx_consts.vh"

module tptx_status (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Live lower half, already active low
    input wire [15:0] low_flags_n,
    // Level status and error events
    input wire tx_ready_for_data,
    input wire link_ready_n,
    input wire [13:0] err_events,
    input wire clear_errors,
    // Status word
    output reg [31:0] status_q
);

    reg [15:0] user_q;
    wire [15:0] user_d;

    // sticky until cleared
    // Set wins over a clear in the same cycle.
    assign user_d = {(user_q[15:2] & {14{~clear_errors}}) | err_events,
                     ~link_ready_n, tx_ready_for_data};

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            user_q <= 16'h0000;
            status_q <= 32'h0000ffff;
        end
        else
        begin
            user_q <= user_d;
            status_q <= {user_d, low_flags_n};
        end
    end

endmodule // tptx_status
`default_nettype wire

// ---- tb/tptx_props.sv ----
// Concurrent checks on the ports of the transmit pattern path and status word.
// Assumes one clock domain and the asynchronous active-low reset of the top module.
`timescale 1ns/100ps
`default_nettype none

module tptx_props (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Watched inputs
    input wire [31:0] control_word,
    input wire [31:0] mode_word,
    input wire rx2_empty_n,
    input wire rx2_full_n,
    input wire rx1_full_n,
    input wire tx2_ren_n,
    input wire jtag_tdo,
    input wire ready_for_data,
    input wire link_ready_n,
    input wire code_violation_flag,
    input wire link_rx_error,
    // Watched outputs
    input wire [31:0] board_status,
    input wire [25:0] transmit_data_pins_q,
    input wire [1:0] ctrl_top_bits_q,
    input wire ctrl_stop_q,
    input wire tx_port_io_oe_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    tdo_bit_a: assert property ($past(reset_n) |-> board_status[11] == $past(jtag_tdo))
        else $error("status tdo bit does not follow the chain");
    rx_flags_a: assert property ($past(reset_n) |-> board_status[1:0] ==
        {$past(rx2_full_n), $past(rx2_empty_n)} && board_status[7] == $past(rx1_full_n))
        else $error("receive fifo flags not passed through");
    link_ready_a: assert property ($past(reset_n) |-> board_status[17:16] ==
        {~$past(link_ready_n), $past(ready_for_data)})
        else $error("link ready bits wrong");
    viol_set_a: assert property ($past(reset_n) && $past(code_violation_flag) |-> board_status[30])
        else $error("code violation did not set its bit");
    rxerr_set_a: assert property ($past(reset_n) && $past(link_rx_error) |-> board_status[31])
        else $error("receiver error did not set its bit");
    sticky_hold_a: assert property (
        (($past(board_status[31:18]) & ~board_status[31:18]) != 14'h0) |-> $past(control_word[29]))
        else $error("error bit dropped without clear");
    clear_err_a: assert property ($past(reset_n) && $past(control_word[29]) &&
        !$past(code_violation_flag) |-> !board_status[30])
        else $error("clear did not remove error bit");
    tx2_active_a: assert property ($past(reset_n) && $past(mode_word[1]) &&
        !$past(tx2_ren_n) |-> !board_status[5])
        else $error("transmit activity bit not low");
    top_bits_a: assert property (ctrl_top_bits_q[0] == transmit_data_pins_q[25])
        else $error("bit 25 differs between pins and controller");
    stop_marker_a: assert property (ctrl_stop_q |-> ctrl_top_bits_q[1])
        else $error("stop without marker word");
    side_oe_a: assert property ($past(reset_n) |-> tx_port_io_oe_q ==
        ($past(mode_word[3]) && !$past(mode_word[31])))
        else $error("side enable does not follow mode");
endmodule // tptx_props

bind tptx_top tptx_props u_props (.core_clk(core_clk), .reset_n(reset_n),
    .control_word(control_word), .mode_word(mode_word), .rx2_empty_n(rx2_empty_n),
    .rx2_full_n(rx2_full_n), .rx1_full_n(rx1_full_n), .tx2_ren_n(tx2_ren_n),
    .jtag_tdo(jtag_tdo), .ready_for_data(ready_for_data), .link_ready_n(link_ready_n),
    .code_violation_flag(code_violation_flag), .link_rx_error(link_rx_error),
    .board_status(board_status), .transmit_data_pins_q(transmit_data_pins_q),
    .ctrl_top_bits_q(ctrl_top_bits_q), .ctrl_stop_q(ctrl_stop_q),
    .tx_port_io_oe_q(tx_port_io_oe_q));
`default_nettype wire

// ---- tb/tptx_card.sv ----
// Pin-level model of the daughter card on the first port pair.
// Assumes the side pins are two-way and the card drives them when the board does not.
`timescale 1ns/100ps
`default_nettype none

module tptx_card (
    // Clock
    input wire logic core_clk,
    // Board side drive
    input wire logic tx_oe,
    input wire logic [8:0] tx_out,
    input wire logic rx_oe,
    input wire logic [8:0] rx_out,
    // Resolved pin levels
    output logic [8:0] tx_io,
    output logic [8:0] rx_io
);
    logic [8:0] spin_q = 9'h0;

    // A changing pattern keeps undriven lines from looking like stale data.
    always @(posedge core_clk)
        spin_q <= spin_q + 9'h25;
    assign tx_io = tx_oe ? tx_out : ~spin_q;
    assign rx_io = rx_oe ? rx_out : spin_q;
endmodule // tptx_card
`default_nettype wire

// ---- tb/test_pattern_tx_fifo_status_test.sv ----
// Self-checking bench for the transmit pattern path and the status word.
// Assumes the design sources, the card model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "tptx_consts.vh"

module test_pattern_tx_fifo_status_test;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [1:0] host_sel = 2'h0;
    logic [31:0] host_wdata = 32'h0;
    logic [31:0] control_word = 32'h0;
    logic [31:0] mode_word = 32'h0;
    logic [3:0] txc = 4'h0;
    logic [15:0] fl = 16'hffff;
    logic [1:0] lnk = 2'h1;
    logic [12:0] ev = 13'h0;
    logic [1:0] ld = 2'h0;
    wire [31:0] rdata, board_status;
    wire [25:0] pins;
    wire [1:0] top_bits;
    wire stop_q, active_q, tx_oe, rx_oe;
    wire [3:0] top_pins;
    wire [8:0] tx_out, rx_out, tx_io, rx_io;
    int err_total = 0;
    int comparisons = 0;

    always #2 core_clk = ~core_clk;

    tptx_top dut (.core_clk(core_clk), .reset_n(reset_n), .host_wr(host_wr), .host_rd(host_rd),
        .host_sel(host_sel), .host_wdata(host_wdata), .host_rdata_q(rdata),
        .control_word(control_word), .mode_word(mode_word), .tx_start(txc[0]),
        .tx_stop(txc[1]), .tx_retransmit(txc[2]), .tx_reset(txc[3]),
        .transmit_data_pins_q(pins), .ctrl_top_bits_q(top_bits), .ctrl_stop_q(stop_q),
        .tx_active_q(active_q), .tx_port_io_in(tx_io), .tx_port_io_out_q(tx_out),
        .tx_port_io_oe_q(tx_oe), .rx_port_io_in(rx_io), .rx_port_io_out_q(rx_out),
        .rx_port_io_oe_q(rx_oe), .side_top_pins_q(top_pins), .rx2_empty_n(fl[0]),
        .rx2_full_n(fl[1]),
        .rx2_wen_n(fl[2]), .tx2_empty_n(fl[3]), .tx2_full_n(fl[4]), .tx2_ren_n(fl[5]),
        .rx1_empty_n(fl[6]), .rx1_full_n(fl[7]), .rx1_wen_n(fl[8]), .jtag_tdo(fl[11]),
        .rx2_side_empty_n(fl[12]), .rx2_side_full_n(fl[13]), .rx1_side_empty_n(fl[14]),
        .rx1_side_full_n(fl[15]), .ready_for_data(lnk[0]), .link_ready_n(lnk[1]),
        .code_violation_flag(ev[11]), .link_rx_error(ev[12]), .link_tx_load(ld[0]),
        .link_tx_unload(ld[1]), .user_error_events(ev[10:0]), .board_status(board_status));

    tptx_card card (.core_clk(core_clk), .tx_oe(tx_oe), .tx_out(tx_out), .rx_oe(rx_oe),
        .rx_out(rx_out), .tx_io(tx_io), .rx_io(rx_io));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse(input int k, input logic [1:0] v);
        if (k < 4)
            txc[k] = 1'b1;
        else
            ld = v;
        tick(1);
        txc = 4'h0;
        ld = 2'h0;
        tick(1);
    endtask

    // The strobe is held high across a burst, one word per cycle.
    task automatic wr_burst(input logic [1:0] sel, input logic [31:0] base,
        input logic [31:0] step, input int n, input int mark);
        host_sel = sel;
        host_wr = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            host_wdata = base + step * i + ((i == mark) ? 32'h04000000 : 32'h0);
            tick(1);
        end
        host_wr = 1'b0;
        tick(1);
    endtask

    task automatic host_read(input logic [1:0] sel, output logic [31:0] d);
        host_sel = sel;
        host_rd = 1'b1;
        tick(1);
        host_rd = 1'b0;
        tick(1);
        d = rdata;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_flags;
        mode_word = 32'h2;
        for (int i = 0; i < 18; i++)
        begin
            fl = (i < 16) ? ~(16'h1 << i) : ((i == 16) ? 16'h0 : 16'hffff);
            tick(2);
            chk("status low half", {fl[15:11], 2'h2, fl[8:0]}, 32'(board_status[15:0]));
        end
        $display("test_flags done");
    endtask

    task automatic test_sticky;
        mode_word = 32'h0;
        lnk = 2'h1;
        ev = 13'h1fff;
        tick(1);
        ev = 13'h0;
        tick(3);
        chk("sticky events", 32'hdfff0000, board_status & 32'hffff0000);
        lnk = 2'h2;
        tick(2);
        chk("link levels", 32'h0, 32'(board_status[17:16]));
        lnk = 2'h1;
        control_word = 32'h20000000;
        ev[12] = 1'b1;
        tick(2);
        control_word = 32'h0;
        ev = 13'h0;
        tick(2);
        chk("clear with event held", 32'h80030000, board_status & 32'hffff0000);
        control_word = 32'h20000000;
        tick(2);
        control_word = 32'h0;
        pulse(4, 2'h1);
        pulse(4, 2'h1);
        pulse(4, 2'h2);
        pulse(4, 2'h1);
        chk("no overwrite", 32'h0, 32'(board_status[29]));
        pulse(4, 2'h1);
        chk("overwrite", 32'h1, 32'(board_status[29]));
        control_word = 32'h20000000;
        tick(2);
        control_word = 32'h0;
        tick(2);
        $display("test_sticky done");
    endtask

    task automatic test_readonly;
        logic [31:0] d;
        wr_burst(`TPTX_SEL_STATUS, 32'hffffffff, 32'h0, 1, -1);
        host_read(`TPTX_SEL_STATUS, d);
        chk("status read", 32'h0003fdff, d);
        host_read(`TPTX_SEL_MAIN, d);
        chk("main fifo read", 32'h0, d);
        host_read(2'h3, d);
        chk("unused read", 32'h0, d);
        $display("test_readonly done");
    endtask

    task automatic test_stream;
        logic [31:0] m, s;
        logic [8:0] t;
        int k;
        mode_word = 32'h0;
        pulse(3, 2'h0);
        wr_burst(`TPTX_SEL_MAIN, 32'h0, 32'h1, 2, -1);
        tick(2);
        chk("deselected write", 32'h0, 32'(board_status[9]));
        mode_word = 32'h8;
        pulse(3, 2'h0);
        wr_burst(`TPTX_SEL_MAIN, 32'h02012340, 32'h111, 6, 3);
        wr_burst(`TPTX_SEL_SIDE, 32'h8a5c0000, 32'h4000, 6, -1);
        tick(2);
        chk("not empty", 32'h1, 32'(board_status[9]));
        pulse(0, 2'h0);
        k = 0;
        while (active_q !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        // Activity rises one cycle before the first word reaches the pins.
        tick(1);
        for (int i = 0; i < 5; i++)
        begin
            m = 32'h02012340 + 32'h111 * i + ((i == 3) ? 32'h04000000 : 32'h0);
            s = 32'h8a5c0000 + 32'h4000 * i;
            chk("data pins", 32'(m[25:0]), 32'(pins));
            chk("top bits", 32'(m[26:25]), 32'(top_bits));
            chk("stop flag", 32'(i == 3), 32'(stop_q));
            chk("side pins", 32'(s[31:14]), {14'h0, tx_out, rx_out});
            chk("side enables", 32'h3, {30'h0, tx_oe, rx_oe});
            chk("tx activity", 32'h0, 32'(board_status[5]));
            tick(1);
        end
        chk("held after stop", 32'(m[25:0]), 32'(pins));
        mode_word = 32'h80000008;
        tick(2);
        chk("tx side receiving", 32'h1, {30'h0, tx_oe, rx_oe});
        chk("tx idle", 32'h1, 32'(board_status[5]));
        t = tx_io;
        tick(1);
        chk("top pins", 32'({t[8:7], rx_out[8:7]}), 32'(top_pins));
        $display("test_stream done");
    endtask

    task automatic test_full;
        int k;
        mode_word = 32'h8;
        pulse(3, 2'h0);
        wr_burst(`TPTX_SEL_MAIN, 32'h0, 32'h1, `TPTX_FIFO_DEPTH + 1, -1);
        tick(2);
        chk("full flags", 32'h1, 32'(board_status[10:9]));
        pulse(0, 2'h0);
        k = 0;
        while (active_q !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        tick(1);
        chk("first word kept", 32'h0, 32'(pins));
        tick(1);
        chk("second word", 32'h1, 32'(pins));
        pulse(1, 2'h0);
        $display("test_full done");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        tick(8);
        reset_n = 1'b1;
        tick(1);
        test_flags();
        test_sticky();
        test_readonly();
        test_stream();
        test_full();
        wrap_up();
    end

    initial
    begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule // test_pattern_tx_fifo_status_test
`default_nettype wire
